// [design/data_eeprom_write_controller.sv]
// Data EEPROM access controller with an AXI4-Lite register and array port.
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_write_controller
	import eeprom_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF,
	parameter int DEPTH       = ARRAY_BYTES,
	parameter int ROW         = LATCH_BYTES
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              external_access_i,
	input  wire logic              readout_protect_i,
	input  wire logic              wait_req_i,
	input  wire logic              halt_req_i,
	output logic                   in_wait_o,
	output logic                   halted_o,
	output logic                   program_mem_erase_o
);
	localparam int IDX_W = $clog2(DEPTH);
	localparam int COL_W = $clog2(ROW);
	localparam int ROW_W = $clog2(DEPTH / ROW);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	ctrl_state_t              state_q, state_d;
	logic                     lat_q, lat_d;
	logic                     pgm_q, pgm_d;
	logic [ROW-1:0][7:0]      latch_q, latch_d;
	logic [ROW-1:0]           mask_q, mask_d;
	logic [ROW_W-1:0]         row_q, row_d;
	logic                     prot_prev_q, prot_prev_d;
	logic                     wait_q, wait_d;
	logic                     erase_q, erase_d;
	logic                     aw_have_q, aw_have_d;
	logic [ADDR_W-1:0]        awaddr_q, awaddr_d;
	logic                     w_have_q, w_have_d;
	logic [7:0]               wbyte_q, wbyte_d;
	logic                     wlane_q, wlane_d;
	logic                     awready_q, awready_d;
	logic                     wready_q, wready_d;
	logic                     bvalid_q, bvalid_d;
	logic [1:0]               bresp_q, bresp_d;
	logic                     arready_q, arready_d;
	logic                     rvalid_q, rvalid_d;
	logic [DATA_W-1:0]        rdata_q, rdata_d;
	logic [1:0]               rresp_q, rresp_d;
	logic                     tmr_start, tmr_abort, tmr_busy, tmr_done;
	logic                     cell_prog, cell_erase;
	logic [7:0]               cell_rd;
	logic [IDX_W-1:0]         rd_idx, wr_idx;
	logic                     rd_in_array, wr_in_array, blocked;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules.
	prog_timer #(
		.CYCLES  (PROG_CYCLES)
	) u_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.start_i (tmr_start),
		.abort_i (tmr_abort),
		.busy_o  (tmr_busy),
		.done_o  (tmr_done)
	);

	eeprom_cells #(
		.DEPTH       (DEPTH),
		.ROW         (ROW)
	) u_cells (
		.clk_i       (clk_i),
		.rd_idx_i    (rd_idx),
		.rd_data_o   (cell_rd),
		.prog_i      (cell_prog),
		.prog_row_i  (row_q),
		.prog_data_i (latch_q),
		.prog_mask_i (mask_q),
		.erase_i     (cell_erase)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	assign rd_in_array = (s_axi_araddr >= ARRAY_BASE) && (s_axi_araddr < ARRAY_LIMIT);
	assign wr_in_array = (awaddr_q >= ARRAY_BASE) && (awaddr_q < ARRAY_LIMIT);
	assign rd_idx      = IDX_W'((s_axi_araddr - ARRAY_BASE) >> 2);
	assign wr_idx      = IDX_W'((awaddr_q - ARRAY_BASE) >> 2);
	assign blocked     = readout_protect_i && external_access_i;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		state_d     = state_q;
		lat_d       = lat_q;
		pgm_d       = pgm_q;
		latch_d     = latch_q;
		mask_d      = mask_q;
		row_d       = row_q;
		prot_prev_d = readout_protect_i;
		erase_d     = 1'b0;
		aw_have_d   = aw_have_q;
		awaddr_d    = awaddr_q;
		w_have_d    = w_have_q;
		wbyte_d     = wbyte_q;
		wlane_d     = wlane_q;
		bvalid_d    = bvalid_q;
		bresp_d     = bresp_q;
		arready_d   = arready_q || !rvalid_q;
		rvalid_d    = rvalid_q;
		rdata_d     = rdata_q;
		rresp_d     = rresp_q;
		tmr_start   = 1'b0;
		tmr_abort   = 1'b0;
		cell_prog   = 1'b0;
		cell_erase  = 1'b0;

		// Write channels are taken in either order; the response follows both.
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wbyte_d  = s_axi_wdata[7:0];
			wlane_d  = s_axi_wstrb[0];
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end

		if (aw_have_q && w_have_q && !bvalid_q) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			if (awaddr_q == CSR_OFFSET) begin
				if (wlane_q) begin
					if (wbyte_q[LAT_BIT]) begin
						lat_d = 1'b1;
					end else if (!pgm_q) begin
						lat_d = 1'b0;
					end
					if (wbyte_q[PGM_BIT] && !pgm_q && state_q == ST_IDLE
							&& (lat_q || wbyte_q[LAT_BIT]) && !blocked) begin
						pgm_d     = 1'b1;
						state_d   = ST_PROG;
						tmr_start = 1'b1;
					end else if (!wbyte_q[PGM_BIT] && pgm_q) begin
						// Clearing the program bit early abandons the cycle.
						pgm_d     = 1'b0;
						state_d   = ST_IDLE;
						tmr_abort = 1'b1;
					end
				end
			end else if (wr_in_array) begin
				// Writes in read mode, during a cycle, or when blocked latch nothing.
				if (lat_q && !pgm_q && wlane_q && !blocked) begin
					latch_d[wr_idx[COL_W-1:0]] = latch_q[wr_idx[COL_W-1:0]] & wbyte_q;
					mask_d[wr_idx[COL_W-1:0]]  = 1'b1;
					row_d = wr_idx[IDX_W-1:COL_W];
				end
			end else begin
				bresp_d = RESP_SLVERR;
			end
		end

		// Reads answer one cycle after the address is taken.
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rdata_d   = '0;
			rresp_d   = RESP_OKAY;
			if (s_axi_araddr == CSR_OFFSET) begin
				rdata_d[PGM_BIT] = pgm_q;
				rdata_d[LAT_BIT] = lat_q;
			end else if (rd_in_array) begin
				if (lat_q || blocked) begin
					rresp_d = RESP_SLVERR;
				end else begin
					rdata_d[7:0] = cell_rd;
				end
			end else begin
				rresp_d = RESP_SLVERR;
			end
		end

		// Cycle end programs the row and clears both bits together.
		if (state_q == ST_PROG && tmr_done) begin
			cell_prog = 1'b1;
			pgm_d     = 1'b0;
			lat_d     = 1'b0;
			state_d   = ST_IDLE;
		end

		if (halt_req_i) begin
			state_d   = ST_HALT;
			tmr_abort = 1'b1;
			pgm_d     = 1'b0;
			lat_d     = 1'b0;
			tmr_start = 1'b0;
		end else if (state_q == ST_HALT) begin
			state_d = ST_IDLE;
		end

		// Protection removed: everything is erased before reuse.
		if (prot_prev_q && !readout_protect_i) begin
			cell_erase = 1'b1;
			erase_d    = 1'b1;
			tmr_abort  = 1'b1;
			tmr_start  = 1'b0;
			pgm_d      = 1'b0;
			lat_d      = 1'b0;
			if (state_d == ST_PROG) begin
				state_d = ST_IDLE;
			end
		end

		if ((state_q == ST_PROG && state_d != ST_PROG) || (lat_q && !lat_d)) begin
			latch_d = {ROW{ERASED_BYTE}};
			mask_d  = '0;
		end
		// A pending cycle runs to its end before wait is entered.
		wait_d = wait_req_i && state_d == ST_IDLE && !tmr_busy;
	end
	assign awready_d = !aw_have_d && !bvalid_d;
	assign wready_d  = !w_have_d && !bvalid_d;

	////////////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q     <= ST_IDLE;
			lat_q       <= CSR_RESET[LAT_BIT];
			pgm_q       <= CSR_RESET[PGM_BIT];
			latch_q     <= {ROW{ERASED_BYTE}};
			mask_q      <= '0;
			row_q       <= '0;
			prot_prev_q <= 1'b0;
			wait_q      <= 1'b0;
			erase_q     <= 1'b0;
			aw_have_q   <= 1'b0;
			awaddr_q    <= '0;
			w_have_q    <= 1'b0;
			wbyte_q     <= '0;
			wlane_q     <= 1'b0;
			awready_q   <= 1'b0;
			wready_q    <= 1'b0;
			bvalid_q    <= 1'b0;
			bresp_q     <= RESP_OKAY;
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b0;
			rdata_q     <= '0;
			rresp_q     <= RESP_OKAY;
		end else begin
			state_q     <= state_d;
			lat_q       <= lat_d;
			pgm_q       <= pgm_d;
			latch_q     <= latch_d;
			mask_q      <= mask_d;
			row_q       <= row_d;
			prot_prev_q <= prot_prev_d;
			wait_q      <= wait_d;
			erase_q     <= erase_d;
			aw_have_q   <= aw_have_d;
			awaddr_q    <= awaddr_d;
			w_have_q    <= w_have_d;
			wbyte_q     <= wbyte_d;
			wlane_q     <= wlane_d;
			awready_q   <= awready_d;
			wready_q    <= wready_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			arready_q   <= arready_d;
			rvalid_q    <= rvalid_d;
			rdata_q     <= rdata_d;
			rresp_q     <= rresp_d;
		end
	end

	assign s_axi_awready       = awready_q;
	assign s_axi_wready        = wready_q;
	assign s_axi_bvalid        = bvalid_q;
	assign s_axi_bresp         = bresp_q;
	assign s_axi_arready       = arready_q;
	assign s_axi_rvalid        = rvalid_q;
	assign s_axi_rdata         = rdata_q;
	assign s_axi_rresp         = rresp_q;
	assign in_wait_o           = wait_q;
	assign halted_o            = state_q[1]; // Only the halt code has its upper bit set.
	assign program_mem_erase_o = erase_q;
endmodule
`default_nettype wire

// [design/eeprom_cells.sv]
// Nonvolatile cell array: byte reads, masked row programming of latched bytes only and bulk erase.
`timescale 1ns/100ps
`default_nettype none
module eeprom_cells
	import eeprom_pkg::*;
#(
	parameter int DEPTH = 128,
	parameter int ROW   = 32
) (
	input  wire logic                         clk_i,
	input  wire logic [$clog2(DEPTH)-1:0]     rd_idx_i,
	output logic      [7:0]                   rd_data_o,
	input  wire logic                         prog_i,
	input  wire logic [$clog2(DEPTH/ROW)-1:0] prog_row_i,
	input  wire logic [ROW*8-1:0]             prog_data_i,
	input  wire logic [ROW-1:0]               prog_mask_i,
	input  wire logic                         erase_i
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];

	// Cells are not reset: their content survives a reset like real storage.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
			if (erase_i) begin
				mem_d[i] = ERASED_BYTE;
			end else if (prog_i && (i / ROW == int'(prog_row_i)) && prog_mask_i[i % ROW]) begin
				mem_d[i] = prog_data_i[(i % ROW)*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		mem_q <= mem_d;
	end

	assign rd_data_o = mem_q[rd_idx_i];
endmodule
`default_nettype wire

// [design/eeprom_pkg.sv]
// Constants shared by the data EEPROM write controller and its submodules.
package eeprom_pkg;

	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam int          ARRAY_BYTES     = 128;
	localparam int          LATCH_BYTES     = 32;

	// Register and array byte addresses on the bus.
	localparam logic [11:0] CSR_OFFSET      = 12'h030;
	localparam logic [11:0] ARRAY_BASE      = 12'h400;
	localparam logic [11:0] ARRAY_LIMIT     = 12'h600;

	// Control/status register fields and reset value.
	localparam int          PGM_BIT         = 0;
	localparam int          LAT_BIT         = 1;
	localparam logic [7:0]  CSR_RESET       = 8'h00;

	// Value of an erased cell and of a cleared data latch.
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

	// Internally timed programming cycle.
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          PROG_TIME_NS    = 5000000;
	localparam int          PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_HALT = 2'b10
	} ctrl_state_t;

endpackage

// [design/prog_timer.sv]
// Counter that times one programming cycle.
`timescale 1ns/100ps
`default_nettype none
module prog_timer #(
	parameter int CYCLES = 500000
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	input  wire logic abort_i,
	output logic      busy_o,
	output logic      done_o
);
	localparam int CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             busy_q;
	logic             busy_d;

	always_comb begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_o = 1'b0;
		if (abort_i) begin
			busy_d = 1'b0;
			cnt_d  = '0;
		end else if (busy_q) begin
			if (cnt_q == LAST) begin
				done_o = 1'b1;
				busy_d = 1'b0;
				cnt_d  = '0;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end else if (start_i) begin
			busy_d = 1'b1;
			cnt_d  = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign busy_o = busy_q;
endmodule
`default_nettype wire

// [dv/core_bus_model.sv]
// Bus master model of the processor core on the register and array port.
`timescale 1ns/100ps
`default_nettype none
module core_bus_model
	import eeprom_pkg::*;
(
	input  wire logic              clk_i,
	output logic      [ADDR_W-1:0] awaddr_o,
	output logic                   awvalid_o,
	input  wire logic              awready_i,
	output logic      [DATA_W-1:0] wdata_o,
	output logic                   wvalid_o,
	input  wire logic              wready_i,
	input  wire logic [1:0]        bresp_i,
	input  wire logic              bvalid_i,
	output logic                   bready_o,
	output logic      [ADDR_W-1:0] araddr_o,
	output logic                   arvalid_o,
	input  wire logic              arready_i,
	input  wire logic [DATA_W-1:0] rdata_i,
	input  wire logic [1:0]        rresp_i,
	input  wire logic              rvalid_i,
	output logic                   rready_o
);
	initial begin
		{awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
		{awaddr_o, wdata_o, araddr_o} = '0;
	end

	// Released lines show inverted values so stale data cannot pass for valid data.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= {{(DATA_W-8){1'b0}}, d};
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		do begin
			@(posedge clk_i);
			if (awvalid_o && awready_i) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (wvalid_o && wready_i) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~wdata_o;
			end
		end while (!bvalid_i);
		r = bresp_i;
		bready_o <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr_o <= a;
		{arvalid_o, rready_o} <= 2'h3;
		do begin
			@(posedge clk_i);
			if (arvalid_o && arready_i) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~a;
			end
		end while (!rvalid_i);
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [dv/data_eeprom_write_controller_test.sv]
// Self-checking testbench for the data EEPROM write controller.
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_write_controller_test
	import eeprom_pkg::*;
;
	localparam int          PROG_N = 40;
	localparam logic [11:0] CSR    = CSR_OFFSET;
	logic              clk_i = 1'b0, rst_n_i = 1'b0;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, rd_v;
	logic [1:0]        bresp, rresp, resp;
	logic              ext_acc = 1'b0, protect = 1'b1, wait_req = 1'b0, halt_req = 1'b0;
	logic              in_wait, halted, erase_pulse;
	int                fail_count = 0, num_checks = 0, n;

	always #5 clk_i = ~clk_i;

	core_bus_model bus (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
		.bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
		.rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

	data_eeprom_write_controller #(.PROG_CYCLES(PROG_N)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_access_i(ext_acc), .readout_protect_i(protect), .wait_req_i(wait_req),
		.halt_req_i(halt_req), .in_wait_o(in_wait), .halted_o(halted),
		.program_mem_erase_o(erase_pulse));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] ea(input int i);
		return ARRAY_BASE + 12'(4 * i);
	endfunction

	task automatic w(input logic [11:0] a, input logic [7:0] d);
		bus.wr(a, d, resp);
		chk(32'(resp), 32'(RESP_OKAY));
	endtask

	task automatic r(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		bus.rd(a, rd_v, resp);
		chk(rd_v, 32'(e));
		chk(32'(resp), 32'(er));
	endtask

	// Polls the control register; only the busy and idle values may be seen.
	task automatic wait_done;
		n = 0;
		do begin
			bus.rd(CSR, rd_v, resp);
			n++;
			if (rd_v !== 32'h3 && rd_v !== 32'h0) chk(rd_v, 32'h0);
		end while (rd_v[0] !== 1'b0 && n < 60);
		chk(rd_v, 32'h0);
	endtask

	task automatic prog_row(input int i, input logic [7:0] d);
		w(CSR, 8'h02);
		w(ea(i), d);
		w(CSR, 8'h03);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_erase;
		r(CSR, 8'h00, RESP_OKAY);
		r(12'h100, 8'h00, RESP_SLVERR);
		protect <= 1'b0;
		n = 0;
		repeat (4) begin
			@(posedge clk_i);
			n += int'(erase_pulse === 1'b1);
		end
		chk(32'(n), 32'h1);
		r(ea(0), ERASED_BYTE, RESP_OKAY);
		r(ea(127), ERASED_BYTE, RESP_OKAY);
		w(ea(1), 8'h00);
		r(ea(1), ERASED_BYTE, RESP_OKAY);
	endtask

	task automatic t_program;
		w(CSR, 8'h02);
		r(CSR, 8'h02, RESP_OKAY);
		r(ea(33), 8'h00, RESP_SLVERR);
		w(ea(33), 8'hF0);
		w(ea(33), 8'h3C);
		w(ea(34), 8'hA5);
		w(CSR, 8'h03);
		r(CSR, 8'h03, RESP_OKAY);
		w(CSR, 8'h01);
		r(CSR, 8'h03, RESP_OKAY);
		wait_done();
		r(ea(33), 8'h30, RESP_OKAY);
		r(ea(34), 8'hA5, RESP_OKAY);
		r(ea(35), ERASED_BYTE, RESP_OKAY);
		r(ea(1), ERASED_BYTE, RESP_OKAY);
	endtask

	task automatic t_fall_clear;
		w(CSR, 8'h02);
		w(ea(64), 8'h0F);
		w(CSR, 8'h00);
		prog_row(64, 8'hF3);
		wait_done();
		r(ea(64), 8'hF3, RESP_OKAY);
	endtask

	task automatic t_wait;
		wait_req <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'(in_wait), 32'h1);
		wait_req <= 1'b0;
		prog_row(96, 8'h55);
		wait_req <= 1'b1;
		repeat (20) begin
			@(posedge clk_i);
			if (in_wait !== 1'b0) chk(32'(in_wait), 32'h0);
		end
		n = 0;
		while (in_wait !== 1'b1 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(in_wait), 32'h1);
		wait_req <= 1'b0;
		r(CSR, 8'h00, RESP_OKAY);
		r(ea(96), 8'h55, RESP_OKAY);
	endtask

	task automatic t_halt;
		prog_row(97, 8'h00);
		halt_req <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'(halted), 32'h1);
		halt_req <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(32'(halted), 32'h0);
		r(CSR, 8'h00, RESP_OKAY);
		r(ea(97), ERASED_BYTE, RESP_OKAY);
	endtask

	task automatic t_protect;
		protect <= 1'b1;
		ext_acc <= 1'b1;
		r(ea(96), 8'h00, RESP_SLVERR);
		ext_acc <= 1'b0;
		w(CSR, 8'h02);
		ext_acc <= 1'b1;
		w(ea(98), 8'h00);
		ext_acc <= 1'b0;
		w(CSR, 8'h03);
		wait_done();
		r(ea(98), ERASED_BYTE, RESP_OKAY);
		r(ea(96), 8'h55, RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		$display("MISMATCH at %0t: timeout", $time);
		conclude();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset_erase();
		t_program();
		t_fall_clear();
		t_wait();
		t_halt();
		t_protect();
		conclude();
	end
endmodule
`default_nettype wire

// [dv/eeprom_ctrl_sva.sv]
// Port-level assertions for the data EEPROM write controller.
`timescale 1ns/100ps
`default_nettype none
module eeprom_ctrl_sva
	import eeprom_pkg::*;
#(
	parameter int PROG_CYCLES = 8
) (
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              readout_protect_i,
	input wire logic              wait_req_i,
	input wire logic              halt_req_i,
	input wire logic              in_wait_o,
	input wire logic              halted_o,
	input wire logic              program_mem_erase_o
);
	logic [ADDR_W-1:0] ar_q;

	always_ff @(posedge clk_i) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ar_q <= s_axi_araddr;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response moved");
	a_csr_reserved: assert property (s_axi_rvalid && ar_q == CSR_OFFSET |-> s_axi_rdata[31:2] == '0)
		else $error("reserved bits not zero");
	a_err_no_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("refused read shows data");
	a_halt_enter: assert property (halt_req_i |=> halted_o)
		else $error("halt not entered");
	a_halt_leave: assert property (halted_o && !halt_req_i |=> !halted_o) else $error("halt not left");
	a_wait_drop: assert property (!wait_req_i |=> !in_wait_o)
		else $error("wait without request");
	a_erase_pulse: assert property ($fell(readout_protect_i) |=> program_mem_erase_o ##1 !program_mem_erase_o)
		else $error("erase pulse wrong");

	c_halt: cover property (halted_o);
	c_erase: cover property (program_mem_erase_o);
	c_wait: cover property (in_wait_o);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind data_eeprom_write_controller eeprom_ctrl_sva #(
	.PROG_CYCLES         (PROG_CYCLES)
) u_sva (
	.clk_i               (clk_i),
	.rst_n_i             (rst_n_i),
	.s_axi_awvalid       (s_axi_awvalid),
	.s_axi_awready       (s_axi_awready),
	.s_axi_wvalid        (s_axi_wvalid),
	.s_axi_wready        (s_axi_wready),
	.s_axi_bresp         (s_axi_bresp),
	.s_axi_bvalid        (s_axi_bvalid),
	.s_axi_bready        (s_axi_bready),
	.s_axi_araddr        (s_axi_araddr),
	.s_axi_arvalid       (s_axi_arvalid),
	.s_axi_arready       (s_axi_arready),
	.s_axi_rdata         (s_axi_rdata),
	.s_axi_rresp         (s_axi_rresp),
	.s_axi_rvalid        (s_axi_rvalid),
	.s_axi_rready        (s_axi_rready),
	.readout_protect_i   (readout_protect_i),
	.wait_req_i          (wait_req_i),
	.halt_req_i          (halt_req_i),
	.in_wait_o           (in_wait_o),
	.halted_o            (halted_o),
	.program_mem_erase_o (program_mem_erase_o)
);
`default_nettype wire
